/* File: playback_ctrl_pkg.sv */
// Package with register map, field layout, reset values and timing constants for the playback control bank.
package playback_ctrl_pkg;

   // Register offsets (printed offsets are not multiples of four, so they are indices).
   localparam logic [15:0] IDX_LEFT_LINE_OUT_MUTE   = 16'h4025;
   localparam logic [15:0] IDX_RIGHT_LINE_OUT_MUTE  = 16'h4026;
   localparam logic [15:0] IDX_SPEAKER_OUT_CONTROL  = 16'h4027;
   localparam logic [15:0] IDX_BEEP_ZERO_CROSS_CTRL = 16'h4028;
   localparam logic [15:0] IDX_PLAYBACK_POWER_MGMT  = 16'h4029;
   localparam logic [15:0] IDX_DAC_CONTROL          = 16'h402A;
   localparam logic [15:0] IDX_LEFT_DAC_VOLUME      = 16'h402B;
   localparam logic [15:0] IDX_RIGHT_DAC_VOLUME     = 16'h402C;
   localparam logic [15:0] IDX_BEEP_GAIN_REQUEST    = 16'h4030;
   localparam logic [15:0] IDX_STATUS               = 16'h4031;

   // Field positions.
   localparam int LINE_MUTE_N_BIT = 1;
   localparam int SPK_GAIN_LSB    = 6;
   localparam int SPK_EN_BIT      = 0;
   localparam int ZC_TIMEOUT_LSB  = 3;
   localparam int ZC_EN_BIT       = 0;
   localparam int SPK_BIAS_LSB    = 6;
   localparam int DAC_BIAS_LSB    = 4;
   localparam int BE_BIAS_LSB     = 2;
   localparam int BE_RIGHT_EN_BIT = 1;
   localparam int BE_LEFT_EN_BIT  = 0;
   localparam int MONO_MODE_LSB   = 6;
   localparam int INVERT_BIT      = 5;
   localparam int DEEMPH_BIT      = 2;
   localparam int DAC_EN_LSB      = 0;
   localparam int BEEP_LEFT_LSB   = 0;
   localparam int BEEP_RIGHT_LSB  = 4;
   localparam int BEEP_MONO_LSB   = 8;

   // Masks of writable bits; reserved bits read as zero.
   localparam logic [7:0] MASK_LINE_MUTE = 8'h02;
   localparam logic [7:0] MASK_SPK       = 8'hC1;
   localparam logic [7:0] MASK_ZC        = 8'h19;
   localparam logic [7:0] MASK_POWER     = 8'hFF;
   localparam logic [7:0] MASK_DAC       = 8'hE7;

   // Reset values.
   localparam logic [7:0]  RST_LINE_MUTE = 8'h00;
   localparam logic [7:0]  RST_SPK       = 8'h00;
   localparam logic [7:0]  RST_ZC        = 8'h19;
   localparam logic [7:0]  RST_POWER     = 8'h00;
   localparam logic [7:0]  RST_DAC       = 8'h00;
   localparam logic [7:0]  RST_VOLUME    = 8'h00;
   localparam logic [11:0] RST_BEEP      = 12'h000;

   // Timing.
   localparam int CLK_HZ          = 125_000_000;
   localparam int TIMEOUT_2P5_US  = 2500;
   localparam int TIMEOUT_2P5_CYC = (CLK_HZ / 1000) * TIMEOUT_2P5_US / 1000;

   typedef enum logic [1:0] {
      MONO_STEREO,
      MONO_LEFT,
      MONO_RIGHT,
      MONO_MIX
   } mono_mode_e;

   typedef struct packed {
      logic [1:0] spk_bias;
      logic [1:0] dac_bias;
      logic [1:0] backend_bias;
      logic       backend_right_en;
      logic       backend_left_en;
   } power_ctrl_s;

   typedef struct packed {
      logic [3:0] mono;
      logic [3:0] right;
      logic [3:0] left;
   } beep_gain_s;

endpackage

/* File: playback_output_control.sv */
// Playback back-end control bank: Wishbone register slave, beep gain zero-cross sync and DAC path.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps

// Summary of operation
// - Left line output passes audio only while its bit 1 is one.
// - Right line output passes audio only while its bit 1 is one.
// - Speaker gain field bits 7:6 select 0, 2, 4 or 6 dB, default 0.
// - Speaker enable bit 0 starts power-up when set, power-down when cleared.
// - Detector timeout bits 4:3 pick 20, 10, 5 or 2.5 ms, reset 2.5.
// - Without a zero crossing before timeout, pending beep gains are forced.
// - Detector enable bit 0 resets to one; when clear, beep gains apply at once.
// - Speaker bias bits 7:6: normal, power saving, enhanced performance.
// - DAC and back-end bias fields: normal, extreme saving, saving, enhanced.
// - Power bit 1 enables right back end, bit 0 the left; both reset off.
// - Mono mode 00 stereo, 01 left to both, 10 right to both.
// - Mono mode 11 feeds half the sum of left and right to both outputs.
// - Invert bit 5 multiplies the DAC output by minus one.
// - De-emphasis bit 2 inserts the filter in the DAC path.
// - DAC enable bits 1:0 switch left and right converters individually.
// - Attenuator code gives 0.375 dB steps from 0 dB to -95.625 dB.
// - Applied attenuation moves one step per audio frame toward the target.
// - With detector on, beep gain applies at next zero crossing or timeout.
module playback_output_control #(
   parameter int SAMPLE_W        = 24,
   parameter int TIMEOUT_2P5_CNT = playback_ctrl_pkg::TIMEOUT_2P5_CYC
) (
   // Clock and reset.
   input  wire logic                            i_ref_clk,
   input  wire logic                            i_sys_rst,
   // Wishbone slave.
   input  wire logic                            i_wb_cyc,
   input  wire logic                            i_wb_stb,
   input  wire logic                            i_wb_we,
   input  wire logic [15:0]                     i_wb_adr,
   input  wire logic [3:0]                      i_wb_sel,
   input  wire logic [31:0]                     i_wb_dat,
   output logic      [31:0]                     o_wb_dat,
   output logic                                 o_wb_ack,
   // Audio stream.
   input  wire logic                            i_frame_tick,
   input  wire logic                            i_beep_zero_cross,
   input  wire logic signed [SAMPLE_W-1:0]      i_dac_left,
   input  wire logic signed [SAMPLE_W-1:0]      i_dac_right,
   output logic signed      [SAMPLE_W-1:0]      o_dac_left,
   output logic signed      [SAMPLE_W-1:0]      o_dac_right,
   // Analog control outputs.
   output logic                                 o_line_left_mute,
   output logic                                 o_line_right_mute,
   output logic      [1:0]                      o_spk_gain,
   output logic                                 o_spk_enable,
   output playback_ctrl_pkg::power_ctrl_s       o_power_ctrl,
   output logic                                 o_deemph_enable,
   output logic                                 o_dac_left_enable,
   output logic                                 o_dac_right_enable,
   output logic      [7:0]                      o_left_atten,
   output logic      [7:0]                      o_right_atten,
   output playback_ctrl_pkg::beep_gain_s        o_beep_gain
);
   import playback_ctrl_pkg::*;

   localparam int TMO_W = $clog2(8 * TIMEOUT_2P5_CNT + 1);

   logic [7:0]  left_line_out_mute;
   logic [7:0]  right_line_out_mute;
   logic [7:0]  speaker_out_control;
   logic [7:0]  beep_zero_cross_control;
   logic [7:0]  playback_power_mgmt;
   logic [7:0]  dac_control;
   logic [7:0]  left_dac_volume;
   logic [7:0]  right_dac_volume;
   beep_gain_s  beep_request;
   logic        beep_pending;
   logic [TMO_W-1:0] tmo_count;
   logic [7:0]  left_applied;
   logic [7:0]  right_applied;

   // Bus decode.
   wire         bus_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire         bus_wr     = bus_req & i_wb_we & i_wb_sel[0];
   wire         bus_wr_hi  = bus_req & i_wb_we & i_wb_sel[1];
   wire         sel_lmute  = (i_wb_adr == IDX_LEFT_LINE_OUT_MUTE);
   wire         sel_rmute  = (i_wb_adr == IDX_RIGHT_LINE_OUT_MUTE);
   wire         sel_spk    = (i_wb_adr == IDX_SPEAKER_OUT_CONTROL);
   wire         sel_zc     = (i_wb_adr == IDX_BEEP_ZERO_CROSS_CTRL);
   wire         sel_pwr    = (i_wb_adr == IDX_PLAYBACK_POWER_MGMT);
   wire         sel_dac    = (i_wb_adr == IDX_DAC_CONTROL);
   wire         sel_lvol   = (i_wb_adr == IDX_LEFT_DAC_VOLUME);
   wire         sel_rvol   = (i_wb_adr == IDX_RIGHT_DAC_VOLUME);
   wire         sel_beep   = (i_wb_adr == IDX_BEEP_GAIN_REQUEST);
   wire         sel_stat   = (i_wb_adr == IDX_STATUS);
   wire [7:0]   wr_byte    = i_wb_dat[7:0];
   wire         beep_write = bus_req & i_wb_we & sel_beep & (i_wb_sel[0] | i_wb_sel[1]);
   wire [11:0]  next_beep_req = {bus_wr_hi ? i_wb_dat[11:8] : beep_request[11:8],
                                 bus_wr ? i_wb_dat[7:0] : beep_request[7:0]};

   // Read multiplexer; unmapped addresses read zero and still acknowledge.
   wire [31:0]  rd_data =
      sel_lmute ? {24'h000000, left_line_out_mute} :
      sel_rmute ? {24'h000000, right_line_out_mute} :
      sel_spk   ? {24'h000000, speaker_out_control} :
      sel_zc    ? {24'h000000, beep_zero_cross_control} :
      sel_pwr   ? {24'h000000, playback_power_mgmt} :
      sel_dac   ? {24'h000000, dac_control} :
      sel_lvol  ? {24'h000000, left_dac_volume} :
      sel_rvol  ? {24'h000000, right_dac_volume} :
      sel_beep  ? {20'h00000, beep_request} :
      sel_stat  ? {15'h0000, beep_pending, right_applied, left_applied} :
      32'h00000000;

   // Zero-crossing timeout select: 2.5 ms base scaled by 1, 2, 4 or 8.
   wire [1:0]   tmo_sel   = beep_zero_cross_control[ZC_TIMEOUT_LSB +: 2];
   wire [TMO_W-1:0] tmo_limit =
      (tmo_sel == 2'b11) ? TMO_W'(TIMEOUT_2P5_CNT) :
      (tmo_sel == 2'b10) ? TMO_W'(2 * TIMEOUT_2P5_CNT) :
      (tmo_sel == 2'b01) ? TMO_W'(4 * TIMEOUT_2P5_CNT) :
                           TMO_W'(8 * TIMEOUT_2P5_CNT);
   wire         zc_enable = beep_zero_cross_control[ZC_EN_BIT];
   wire         tmo_hit   = (tmo_count >= tmo_limit - TMO_W'(1));
   wire         beep_apply = beep_pending & (~zc_enable | i_beep_zero_cross | tmo_hit);

   // Attenuator slew, one step per frame toward the latest target.
   wire [7:0]   next_left_applied  = (left_applied < left_dac_volume) ? left_applied + 8'h01 :
                                     (left_applied > left_dac_volume) ? left_applied - 8'h01 :
                                     left_applied;
   wire [7:0]   next_right_applied = (right_applied < right_dac_volume) ? right_applied + 8'h01 :
                                     (right_applied > right_dac_volume) ? right_applied - 8'h01 :
                                     right_applied;

   // DAC routing and polarity; the sum is halved so the mix cannot clip.
   wire signed [SAMPLE_W:0] mix_sum = i_dac_left + i_dac_right;
   wire signed [SAMPLE_W-1:0] mix_half = mix_sum[SAMPLE_W:1];
   wire [1:0]   mono_mode = dac_control[MONO_MODE_LSB +: 2];
   wire signed [SAMPLE_W-1:0] route_left =
      (mono_mode == MONO_RIGHT) ? i_dac_right :
      (mono_mode == MONO_MIX)   ? mix_half : i_dac_left;
   wire signed [SAMPLE_W-1:0] route_right =
      (mono_mode == MONO_LEFT)  ? i_dac_left :
      (mono_mode == MONO_MIX)   ? mix_half : i_dac_right;
   wire         invert    = dac_control[INVERT_BIT];
   wire signed [SAMPLE_W-1:0] next_out_left  = invert ? SAMPLE_W'(-route_left) : route_left;
   wire signed [SAMPLE_W-1:0] next_out_right = invert ? SAMPLE_W'(-route_right) : route_right;

   // Bus slave.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= bus_req;
         o_wb_dat <= bus_req ? rd_data : 32'h00000000;
      end
   end

   // Control registers.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         left_line_out_mute      <= RST_LINE_MUTE;
         right_line_out_mute     <= RST_LINE_MUTE;
         speaker_out_control     <= RST_SPK;
         beep_zero_cross_control <= RST_ZC;
         playback_power_mgmt     <= RST_POWER;
         dac_control             <= RST_DAC;
         left_dac_volume         <= RST_VOLUME;
         right_dac_volume        <= RST_VOLUME;
      end else begin
         if (bus_wr & sel_lmute) left_line_out_mute <= wr_byte & MASK_LINE_MUTE;
         if (bus_wr & sel_rmute) right_line_out_mute <= wr_byte & MASK_LINE_MUTE;
         if (bus_wr & sel_spk) speaker_out_control <= wr_byte & MASK_SPK;
         if (bus_wr & sel_zc) beep_zero_cross_control <= wr_byte & MASK_ZC;
         if (bus_wr & sel_pwr) playback_power_mgmt <= wr_byte & MASK_POWER;
         if (bus_wr & sel_dac) dac_control <= wr_byte & MASK_DAC;
         if (bus_wr & sel_lvol) left_dac_volume <= wr_byte;
         if (bus_wr & sel_rvol) right_dac_volume <= wr_byte;
      end
   end

   // Beep gain request and zero-crossing synchroniser.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         beep_request <= RST_BEEP;
         beep_pending <= 1'b0;
         tmo_count    <= '0;
         o_beep_gain  <= RST_BEEP;
      end else begin
         if (beep_write) begin
            beep_request <= next_beep_req;
            beep_pending <= 1'b1;
            tmo_count    <= '0;
         end else if (beep_apply) begin
            o_beep_gain  <= beep_request;
            beep_pending <= 1'b0;
            tmo_count    <= '0;
         end else if (beep_pending) begin
            tmo_count <= tmo_count + TMO_W'(1);
         end
      end
   end

   // Attenuator slew and DAC sample path.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         left_applied  <= RST_VOLUME;
         right_applied <= RST_VOLUME;
         o_dac_left    <= '0;
         o_dac_right   <= '0;
      end else begin
         if (i_frame_tick) begin
            left_applied  <= next_left_applied;
            right_applied <= next_right_applied;
            o_dac_left    <= dac_control[DAC_EN_LSB] ? next_out_left : '0;
            o_dac_right   <= dac_control[DAC_EN_LSB + 1] ? next_out_right : '0;
         end
      end
   end

   // Registered control outputs.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_line_left_mute   <= 1'b1;
         o_line_right_mute  <= 1'b1;
         o_spk_gain         <= 2'b00;
         o_spk_enable       <= 1'b0;
         o_power_ctrl       <= '0;
         o_deemph_enable    <= 1'b0;
         o_dac_left_enable  <= 1'b0;
         o_dac_right_enable <= 1'b0;
         o_left_atten       <= RST_VOLUME;
         o_right_atten      <= RST_VOLUME;
      end else begin
         o_line_left_mute   <= ~left_line_out_mute[LINE_MUTE_N_BIT];
         o_line_right_mute  <= ~right_line_out_mute[LINE_MUTE_N_BIT];
         o_spk_gain         <= speaker_out_control[SPK_GAIN_LSB +: 2];
         o_spk_enable       <= speaker_out_control[SPK_EN_BIT];
         o_power_ctrl       <= power_ctrl_s'(playback_power_mgmt);
         o_deemph_enable    <= dac_control[DEEMPH_BIT];
         o_dac_left_enable  <= dac_control[DAC_EN_LSB];
         o_dac_right_enable <= dac_control[DAC_EN_LSB + 1];
         o_left_atten       <= left_applied;
         o_right_atten      <= right_applied;
      end
   end

endmodule

/* File: wb_host_model.sv */
// Wishbone classic master standing in for the host that programs the bank.
`timescale 1ns/1ps
module wb_host_model (
   // Bus.
   input  wire logic        i_clk,
   input  wire logic        i_ack,
   input  wire logic [31:0] i_rdat,
   output logic             o_cyc,
   output logic             o_we,
   output logic [15:0]      o_adr,
   output logic [31:0]      o_dat
);
   initial {o_cyc, o_we, o_adr, o_dat} = '0;
   // One classic cycle; the request is held until ack is seen at a rising edge.
   task automatic xfer(input logic we, input logic [15:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_clk);
      o_cyc <= 1'b1;
      o_we  <= we;
      o_adr <= adr;
      o_dat <= wd;
      do @(posedge i_clk); while (i_ack !== 1'b1);
      rd = i_rdat;
      o_cyc <= 1'b0;
      // Released lines change so a stale value is never mistaken for a live one.
      o_adr <= ~adr;
      o_dat <= ~wd;
   endtask
endmodule

/* File: playback_output_control_checker.sv */
// Port checks for the playback control bank.
`timescale 1ns/1ps
module playback_output_control_checker
   import playback_ctrl_pkg::*;
#(parameter int SAMPLE_W = 24) (
   // Clock, reset and bus.
   input wire logic                       i_ref_clk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
   input wire logic [15:0]                i_wb_adr,
   input wire logic [3:0]                 i_wb_sel,
   input wire logic [31:0]                i_wb_dat, o_wb_dat,
   // Stream and control outputs.
   input wire logic                       i_frame_tick, o_line_left_mute, o_line_right_mute, o_spk_enable,
   input wire logic                       o_deemph_enable, o_dac_left_enable, o_dac_right_enable,
   input wire logic [1:0]                 o_spk_gain,
   input wire logic [7:0]                 o_left_atten, o_right_atten,
   input wire logic signed [SAMPLE_W-1:0] o_dac_left,
   input wire power_ctrl_s                o_power_ctrl
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic take = i_wb_cyc && i_wb_stb && !o_wb_ack;
   // A write is taken at one edge and its field copies show two edges later.
   sequence wr_to(logic [15:0] a);
      take && i_wb_we && i_wb_sel[0] && i_wb_adr == a;
   endsequence
   ack_after_take_a: assert property (take |=> o_wb_ack) else $error("no ack after request");
   ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
   idle_data_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data without ack");
   left_mute_a:
      assert property (wr_to(16'h4025) |-> ##2 o_line_left_mute == !$past(i_wb_dat[1], 2)) else $error("left mute");
   right_mute_a:
      assert property (wr_to(16'h4026) |-> ##2 o_line_right_mute == !$past(i_wb_dat[1], 2)) else $error("right mute");
   speaker_field_a:
      assert property (wr_to(16'h4027) |-> ##2 {o_spk_gain, o_spk_enable} ==
                       {$past(i_wb_dat[7:6], 2), $past(i_wb_dat[0], 2)}) else $error("speaker field");
   power_field_a:
      assert property (wr_to(16'h4029) |-> ##2 o_power_ctrl == $past(i_wb_dat[7:0], 2)) else $error("power field");
   dac_field_a:
      assert property (wr_to(16'h402A) |-> ##2 {o_deemph_enable, o_dac_right_enable, o_dac_left_enable} ==
                       $past(i_wb_dat[2:0], 2)) else $error("dac field");
   dac_off_a:
      assert property (i_frame_tick ##1 !o_dac_left_enable |-> o_dac_left == '0) else $error("disabled dac output");
   left_slew_a:
      assert property ($changed(o_left_atten) |-> $past(i_frame_tick, 2) &&
                       (o_left_atten - $past(o_left_atten)) inside {8'h01, 8'hFF}) else $error("left slew");
   right_slew_a:
      assert property ($changed(o_right_atten) |-> $past(i_frame_tick, 2) &&
                       (o_right_atten - $past(o_right_atten)) inside {8'h01, 8'hFF}) else $error("right slew");
endmodule
bind playback_output_control playback_output_control_checker #(.SAMPLE_W(SAMPLE_W)) i_checker (.*);

/* File: playback_output_control_tb.sv */
// Self-checking testbench for the playback control bank.
`timescale 1ns/1ps
module playback_output_control_tb;
   import playback_ctrl_pkg::*;
   localparam int SW = 24;
   localparam int TO = 20;
   // The last index is unmapped, so it reads zero whatever is written.
   localparam logic [15:0] ADRS [9] = '{16'h4025, 16'h4026, 16'h4027, 16'h4028, 16'h4029, 16'h402A, 16'h402B,
                                        16'h402C, 16'h4040};
   localparam logic [7:0]  MSKS [9] = '{8'h02, 8'h02, 8'hC1, 8'h19, 8'hFF, 8'hE7, 8'hFF, 8'hFF, 8'h00};
   logic                 i_ref_clk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_frame_tick;
   logic                 i_beep_zero_cross, o_line_left_mute, o_line_right_mute, o_spk_enable;
   logic                 o_deemph_enable, o_dac_left_enable, o_dac_right_enable;
   logic [1:0]           o_spk_gain;
   logic [3:0]           i_wb_sel;
   logic [15:0]          i_wb_adr;
   logic [31:0]          i_wb_dat, o_wb_dat, rd, r;
   logic [31:0]          seed = 32'hF374;
   logic [7:0]           o_left_atten, o_right_atten, ctl, tgt_l, tgt_r, exp_l, exp_r;
   logic [11:0]          bg, nb;
   logic signed [SW-1:0] i_dac_left, i_dac_right, o_dac_left, o_dac_right, sl, sr;
   power_ctrl_s          o_power_ctrl;
   beep_gain_s           o_beep_gain;
   int                   bad_count = 0;
   int                   num_checks = 0;
   assign i_wb_stb = i_wb_cyc;
   playback_output_control #(.SAMPLE_W(SW), .TIMEOUT_2P5_CNT(TO)) i_playback_output_control (.*);
   wb_host_model i_wb_host_model (.i_clk(i_ref_clk), .i_ack(o_wb_ack), .i_rdat(o_wb_dat), .o_cyc(i_wb_cyc),
                                  .o_we(i_wb_we), .o_adr(i_wb_adr), .o_dat(i_wb_dat));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic signed [SW-1:0] route(input logic [1:0] m, input logic inv,
                                                input logic signed [SW-1:0] a, b, input logic left);
      logic signed [SW:0]   s;
      logic signed [SW-1:0] v;
      s = a + b;
      v = (m == 2'b00) ? (left ? a : b) : (m == 2'b01) ? a : (m == 2'b10) ? b : s[SW:1];
      return inv ? -v : v;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      i_wb_host_model.xfer(1'b1, a, d, rd);
   endtask
   task automatic rdr(input logic [15:0] a);
      i_wb_host_model.xfer(1'b0, a, 32'h0, rd);
   endtask
   task automatic frame(input logic signed [SW-1:0] l, input logic signed [SW-1:0] rr);
      @(posedge i_ref_clk);
      i_frame_tick <= 1'b1;
      i_dac_left   <= l;
      i_dac_right  <= rr;
      @(posedge i_ref_clk);
      i_frame_tick <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end
   initial begin
      {i_sys_rst, i_frame_tick, i_beep_zero_cross, i_wb_sel} = 7'b1000011;
      {i_dac_left, i_dac_right} = '0;
      repeat (8) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      chk({o_line_left_mute, o_line_right_mute, o_beep_gain}, 14'h3000);
      for (int k = 0; k < 9; k++) begin
         rdr(ADRS[k]);
         chk(rd, (k == 3) ? 32'h19 : 32'h0);
         r = rnd();
         wr(ADRS[k], r);
         rdr(ADRS[k]);
         chk(rd, {24'h0, r[7:0] & MSKS[k]});
      end
      $display("test registers done");
      // Gain is swept only here, before any audio frame runs.
      for (int g = 0; g < 4; g++) begin
         r = rnd();
         wr(16'h4025, {30'h0, g[0], 1'b0});
         wr(16'h4026, {30'h0, g[1], 1'b0});
         wr(16'h4027, {24'h0, g[1:0], 5'h00, r[0]});
         wr(16'h4029, r);
         repeat (2) @(posedge i_ref_clk);
         chk({o_line_left_mute, o_line_right_mute}, {!g[0], !g[1]});
         chk({o_spk_gain, o_spk_enable, o_power_ctrl}, {g[1:0], r[0], r[7:0]});
      end
      $display("test controls done");
      {tgt_l, tgt_r, exp_l, exp_r} = {8'h03, 8'hFF, 16'h0};
      wr(16'h402B, tgt_l);
      wr(16'h402C, tgt_r);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         ctl = {i[1:0], i[2], 2'b00, r[2:0]};
         wr(16'h402A, ctl);
         // A new target mid-ramp turns the slew around from where it stands.
         if (i == 2) begin
            tgt_l = 8'h00;
            wr(16'h402B, tgt_l);
         end
         {sl, sr} = {r[31:8], r[23:0]};
         if (i == 7)
            sl = {1'b1, {(SW - 1){1'b0}}};
         frame(sl, sr);
         exp_l = exp_l + (tgt_l > exp_l) - (tgt_l < exp_l);
         exp_r = exp_r + (tgt_r > exp_r) - (tgt_r < exp_r);
         chk(o_dac_left[SW-1:0], ctl[0] ? route(ctl[7:6], ctl[5], sl, sr, 1'b1) : '0);
         chk(o_dac_right[SW-1:0], ctl[1] ? route(ctl[7:6], ctl[5], sl, sr, 1'b0) : '0);
         chk({o_deemph_enable, o_dac_right_enable, o_dac_left_enable, o_left_atten, o_right_atten},
             {ctl[2:0], exp_l, exp_r});
      end
      rdr(16'h4031);
      chk(rd, {16'h0, exp_r, exp_l});
      $display("test dac path done");
      bg = 12'h000;
      wr(16'h4028, 8'h19);
      r = rnd();
      nb = bg ^ (r[11:0] | 12'h001);
      wr(16'h4030, nb);
      repeat (4) @(posedge i_ref_clk);
      chk(o_beep_gain, bg);
      @(posedge i_ref_clk);
      i_beep_zero_cross <= 1'b1;
      @(posedge i_ref_clk);
      i_beep_zero_cross <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      bg = nb;
      chk(o_beep_gain, bg);
      for (int c = 0; c < 4; c++) begin
         r = rnd();
         nb = bg ^ (r[11:0] | 12'h001);
         wr(16'h4028, {27'h0, c[1:0], 3'b001});
         wr(16'h4030, nb);
         repeat ((TO << (3 - c)) - 4) @(posedge i_ref_clk);
         chk(o_beep_gain, bg);
         repeat (8) @(posedge i_ref_clk);
         bg = nb;
         chk(o_beep_gain, bg);
      end
      wr(16'h4028, 8'h18);
      nb = ~bg;
      wr(16'h4030, nb);
      repeat (3) @(posedge i_ref_clk);
      chk(o_beep_gain, nb);
      rdr(16'h4030);
      chk(rd, {20'h0, nb});
      $display("test beep done");
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      chk({o_line_left_mute, o_beep_gain, o_left_atten}, 21'h100000);
      $display("test second reset done");
      end_of_test();
   end
endmodule
